//--- design/fri_fuse_readout.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module fri_fuse_readout (
  input  wire  logic                                   pclk,
  input  wire  logic                                   presetn,
  input  wire  logic                                   clk_en,
  input  wire  fri_pkg::fri_apb_req_t                  apb_req,
  output logic [fri_pkg::DATA_W-1:0]                   prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  input  wire  logic                                   pgm_done,
  input  wire  logic                                   read_done,
  input  wire  logic [fri_pkg::SYS_WORDS-1:0][31:0]    fuse_sys,
  input  wire  logic [fri_pkg::KEY_BLOCKS-1:0][255:0]  fuse_key_enc,
  output logic                                         irq,
  output logic [fri_pkg::SYS_WORDS-1:0][31:0]          sys_param,
  output logic [fri_pkg::KEY_BLOCKS-1:0][255:0]        key_block
);
  import fri_pkg::*;

  logic [1:0]                         irq_raw_q;
  logic [1:0]                         irq_raw_d;
  logic [1:0]                         irq_ena_q;
  logic [1:0]                         irq_set;
  logic [1:0]                         irq_clr;
  logic                               wr_acc;
  logic                               setup;
  logic                               rd_hit;
  logic [DATA_W-1:0]                  rd_data;
  fri_coding_t                        coding;
  logic [KEY_BLOCKS-1:0][KEY_BITS-1:0] key_dec;

  assign setup  = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  assign coding = fri_coding_t'(fuse_sys[CODING_WORD][CODING_LSB +: 2]);

  // Decoding of each key block into its plain value
  genvar gb, gj;
  generate
    for (gb = 0; gb < KEY_BLOCKS; gb++) begin : g_blk
      logic [VALID_34-1:0] dec34;
      for (gj = 0; gj < VALID_34 / 8; gj++) begin : g_byte
        // Six data bytes followed by two check bytes per group
        assign dec34[gj*8 +: 8] =
          fuse_key_enc[gb][((gj / 6) * 8 + (gj % 6)) * 8 +: 8];
      end
      always_comb begin
        key_dec[gb] = fuse_key_enc[gb];
        case (coding)
          FRI_CODE_34:  key_dec[gb] = {{(KEY_BITS-VALID_34){1'b0}}, dec34};
          FRI_CODE_REP: key_dec[gb] = {{(KEY_BITS-VALID_REP){1'b0}},
                                      fuse_key_enc[gb][VALID_REP-1:0]};
          default:      key_dec[gb] = fuse_key_enc[gb];
        endcase
      end
    end
  endgenerate

  // latch decoded values on read done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_param <= '0;
      key_block <= '0;
    end else if (clk_en && read_done) begin
      sys_param <= fuse_sys;
      key_block <= key_dec;
    end
  end

  always_comb begin
    irq_set = 2'b00;
    irq_set[IRQ_PGM_BIT]  = pgm_done;
    irq_set[IRQ_READ_BIT] = read_done;
    irq_clr = 2'b00;
    if (wr_acc && apb_req.paddr == OFF_IRQ_CLEAR) begin
      irq_clr = apb_req.pwdata[1:0];
    end
    irq_raw_d = (irq_raw_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_raw_q <= IRQ_RAW_RST;
    end else if (clk_en) begin
      irq_raw_q <= irq_raw_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ena_q <= IRQ_ENABLE_RST;
    end else if (clk_en && wr_acc && apb_req.paddr == OFF_IRQ_ENABLE) begin
      irq_ena_q <= apb_req.pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_raw_q & irq_ena_q);
    end
  end

  // software has no path to wiring
  always_comb begin
    logic [ADDR_W-1:0] kbase;
    kbase   = OFF_KEY1_BASE;
    rd_hit  = 1'b0;
    rd_data = WORD_RST;
    for (int w = 0; w < SYS_WORDS; w++) begin
      if (apb_req.paddr == OFF_SYS_BASE + ADDR_W'(4 * w)) begin
        rd_hit  = 1'b1;
        rd_data = sys_param[w];
      end
    end
    for (int b = 0; b < KEY_BLOCKS; b++) begin
      kbase = (b == 0) ? OFF_KEY1_BASE :
              (b == 1) ? OFF_KEY2_BASE : OFF_KEY3_BASE;
      for (int w = 0; w < KEY_WORDS; w++) begin
        if (apb_req.paddr == kbase + ADDR_W'(4 * w)) begin
          rd_hit  = 1'b1;
          rd_data = key_block[b][w*32 +: 32];
        end
      end
    end
    case (apb_req.paddr)
      OFF_IRQ_RAW: begin
        rd_hit  = 1'b1;
        rd_data = {30'h0, irq_raw_q};
      end
      OFF_IRQ_STATUS: begin
        rd_hit  = 1'b1;
        rd_data = {30'h0, irq_raw_q & irq_ena_q};
      end
      OFF_IRQ_ENABLE: begin
        rd_hit  = 1'b1;
        rd_data = {30'h0, irq_ena_q};
      end
      OFF_IRQ_CLEAR: begin
        rd_hit  = 1'b1;
        rd_data = WORD_RST;
      end
      default: begin
        rd_hit  = rd_hit;
        rd_data = rd_data;
      end
    endcase
  end

  // Answer staged at setup, stands through one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= WORD_RST;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      if (setup && !apb_req.pwrite) begin
        prdata <= rd_data;
      end
    end
  end

endmodule : fri_fuse_readout

//--- design/fri_pkg.sv
package fri_pkg;

  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int SYS_WORDS  = 7;
  localparam int KEY_BLOCKS = 3;
  localparam int KEY_WORDS  = 8;
  localparam int KEY_BITS   = 256;
  localparam int VALID_34   = 192;
  localparam int VALID_REP  = 128;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SYS_BASE   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_KEY1_BASE  = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_KEY2_BASE  = 12'h058;
  localparam logic [ADDR_W-1:0] OFF_KEY3_BASE  = 12'h078;
  localparam logic [ADDR_W-1:0] OFF_IRQ_RAW    = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h108;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 12'h10c;

  // Interrupt field positions
  localparam int IRQ_READ_BIT = 0;
  localparam int IRQ_PGM_BIT  = 1;

  // Coding scheme field in system word 6
  localparam int CODING_WORD = 6;
  localparam int CODING_LSB  = 0;

  // Reset values
  localparam logic [1:0]        IRQ_RAW_RST    = 2'h0;
  localparam logic [1:0]        IRQ_ENABLE_RST = 2'h0;
  localparam logic [DATA_W-1:0] WORD_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    FRI_CODE_NONE = 2'h0,
    FRI_CODE_34   = 2'h1,
    FRI_CODE_REP  = 2'h2,
    FRI_CODE_RSV  = 2'h3
  } fri_coding_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } fri_apb_req_t;

endpackage : fri_pkg

//--- sim/fri_fuse_readout_sva.sv
`timescale 1ns/100ps
module fri_fuse_readout_sva (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  clk_en,
  input wire fri_pkg::fri_apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  pgm_done,
  input wire logic                  read_done,
  input wire logic [6:0][31:0]      fuse_sys,
  input wire logic [2:0][255:0]     fuse_key_enc,
  input wire logic                  irq,
  input wire logic [6:0][31:0]      sys_param,
  input wire logic [2:0][255:0]     key_block
);
  import fri_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] cs;
  logic       rd;
  assign cs = fuse_sys[6][1:0];
  assign rd = read_done && clk_en;
  a_sys_latch: assert property (
    rd |=> sys_param == $past(fuse_sys)) else $error("sys not latched");
  a_sys_hold: assert property (
    !read_done |=> $stable(sys_param)) else $error("sys changed");
  a_key_hold: assert property (
    !read_done |=> $stable(key_block)) else $error("key changed");
  a_key_none: assert property (
    rd && cs == 2'h0 |=> key_block == $past(fuse_key_enc))
    else $error("uncoded key wrong");
  a_key_three: assert property (
    rd && cs == 2'h1 |=> key_block[0][255:192] == 64'h0)
    else $error("coded key high bits set");
  a_key_rep: assert property (
    rd && cs == 2'h2 |=> key_block[1][127:0] == $past(fuse_key_enc[1][127:0])
    && key_block[1][255:128] == 128'h0) else $error("repeat key wrong");
  a_ready_setup: assert property (
    apb_req.psel && !apb_req.penable && clk_en |=> pready)
    else $error("no ready");
  a_ready_once: assert property (
    pready && clk_en |=> !pready) else $error("ready too long");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  cover property (rd ##2 irq);
  cover property (pslverr);
  cover property ($fell(irq));
endmodule : fri_fuse_readout_sva

bind fri_fuse_readout fri_fuse_readout_sva u_sva (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pgm_done(pgm_done),
  .read_done(read_done), .fuse_sys(fuse_sys), .fuse_key_enc(fuse_key_enc),
  .irq(irq), .sys_param(sys_param), .key_block(key_block));

//--- sim/fri_tb.sv
`timescale 1ns/100ps
module testbench;
  import fri_pkg::*;
  logic pclk = 0, presetn = 0, clk_en = 1, pgm_done = 0, read_done = 0;
  fri_apb_req_t q = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, irq, e;
  logic [6:0][31:0] fuse_sys = '0, sys_param;
  logic [2:0][255:0] fuse_key_enc = '0, key_block, x;
  int failures = 0, num_checks = 0, cyc = 0;
  fri_fuse_readout u_fri_fuse_readout (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .apb_req(q), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pgm_done(pgm_done), .read_done(read_done),
    .fuse_sys(fuse_sys), .fuse_key_enc(fuse_key_enc), .irq(irq),
    .sys_param(sys_param), .key_block(key_block));
  initial begin
    forever #10 pclk = ~pclk;
  end
  task finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task chk(input string s, input logic [255:0] v, input logic [255:0] w);
    num_checks++;
    if (v !== w) begin
      failures++;
      $display("Error %s exp %h got %h", s, w, v);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    q <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    q.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    q <= '0;
    @(posedge pclk);
  endtask : apb
  task rdc(input string s, input logic [11:0] a, input logic [31:0] w);
    apb(0, a, 32'h0);
    chk(s, r, w);
  endtask : rdc
  // pulse pgm_done (p=1) or read_done (p=0) for one cycle, then wait two cycles
  task ev(input logic p);
    if (p) pgm_done <= 1'b1;
    else read_done <= 1'b1;
    @(posedge pclk);
    pgm_done <= 1'b0;
    read_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : ev
  task s_irq;
    rdc("raw_rst", OFF_IRQ_RAW, 32'h0);
    rdc("ena_rst", OFF_IRQ_ENABLE, 32'h0);
    ev(1);
    rdc("raw_pgm", OFF_IRQ_RAW, 32'h2);
    rdc("st_off", OFF_IRQ_STATUS, 32'h0);
    chk("irq_off", irq, 1'b0);
    apb(1, OFF_IRQ_ENABLE, 32'h3);
    rdc("ena", OFF_IRQ_ENABLE, 32'h3);
    chk("irq_on", irq, 1'b1);
    rdc("st_pgm", OFF_IRQ_STATUS, 32'h2);
    ev(0);
    rdc("raw_both", OFF_IRQ_RAW, 32'h3);
    apb(1, OFF_IRQ_CLEAR, 32'h2);
    rdc("raw_clr", OFF_IRQ_RAW, 32'h1);
    rdc("st_rd", OFF_IRQ_STATUS, 32'h1);
    apb(1, OFF_IRQ_CLEAR, 32'h1);
    rdc("clr_rd", OFF_IRQ_CLEAR, 32'h0);
    chk("irq_clr", irq, 1'b0);
  endtask : s_irq
  task s_keys;
    for (int c = 0; c < 4; c++) begin
      fuse_sys[6] <= 32'h0 | c;
      fuse_sys[0] <= 32'h5a00_0000 | c;
      for (int i = 0; i < 96; i++)
        fuse_key_enc[i / 32][8 * (i % 32) +: 8] <= 8'(i * 7 + c + 1);
      @(posedge pclk);
      x = '0;
      for (int b = 0; b < 3; b++)
        if (c == 0 || c == 3) x[b] = fuse_key_enc[b];
        else if (c == 2) x[b][127:0] = fuse_key_enc[b][127:0];
        else for (int g = 0; g < 4; g++)
          x[b][48 * g +: 48] = fuse_key_enc[b][64 * g +: 48];
      ev(0);
      for (int b = 0; b < 3; b++)
        chk("keys", key_block[b], x[b]);
      chk("sys", sys_param[6], 32'h0 | c);
      rdc("sys0", OFF_SYS_BASE, 32'h5a00_0000 | c);
      rdc("k1w0", OFF_KEY1_BASE, x[0][31:0]);
      rdc("k2w4", 12'h068, x[1][159:128]);
      rdc("k3w7", 12'h094, x[2][255:224]);
      apb(1, OFF_KEY1_BASE, 32'hffff_ffff);
      rdc("k1ro", OFF_KEY1_BASE, x[0][31:0]);
    end
  endtask : s_keys
  task s_hold;
    apb(1, OFF_IRQ_CLEAR, 32'h3);
    rdc("raw_zero", OFF_IRQ_RAW, 32'h0);
    clk_en <= 1'b0;
    read_done <= 1'b1;
    fuse_sys[0] <= 32'h0000_00a5;
    @(posedge pclk);
    read_done <= 1'b0;
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc("raw_frz", OFF_IRQ_RAW, 32'h0);
    chk("sys_frz", sys_param[0], 32'h5a00_0003);
  endtask : s_hold
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_irq();
    s_keys();
    s_hold();
    apb(0, 12'h200, 32'h0);
    chk("err", {e, r}, 33'h1_0000_0000);
    finish_test();
  end
endmodule : testbench
